// >>> core/scr_pkg.sv
// constants and types shared by the system-control register bank
package scr_pkg;

  localparam int unsigned XLEN      = 64;
  localparam int unsigned HALF      = 32;
  localparam int unsigned PA_BITS   = 52;
  localparam int unsigned PRIO_BITS = 4;
  localparam int unsigned SEL_W     = 5;

  // register select codes seen on the move port
  localparam logic [4:0] SEL_MODE     = 5'h00;
  localparam logic [4:0] SEL_FAULT    = 5'h02;
  localparam logic [4:0] SEL_TABLE    = 5'h03;
  localparam logic [4:0] SEL_FEATURE  = 5'h04;
  localparam logic [4:0] SEL_PRIORITY = 5'h08;
  localparam logic [4:0] SEL_FLAGS    = 5'h10;
  localparam logic [4:0] SEL_EXTFEAT  = 5'h11;

  // mode-control bit positions
  localparam int unsigned BIT_PROTECTION = 0;
  localparam int unsigned BIT_MONITOR    = 1;
  localparam int unsigned BIT_EMULATE    = 2;
  localparam int unsigned BIT_SWITCHED   = 3;
  localparam int unsigned BIT_EXT_KIND   = 4;
  localparam int unsigned BIT_NUMERIC    = 5;

  localparam logic [63:0] EXT_KIND_MASK = 64'h0000_0000_0000_0010;
  localparam logic [63:0] LOW_MASK      = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] MODE_RESET    = 64'h0000_0000_0000_0010;
  localparam logic [63:0] ZERO_RESET    = 64'h0000_0000_0000_0000;

  // instruction kind, one-hot
  localparam logic [2:0] KIND_WAIT  = 3'h1;
  localparam logic [2:0] KIND_FP    = 3'h2;
  localparam logic [2:0] KIND_MEDIA = 3'h4;

  typedef enum logic [1:0] {
    SCR_ST_IDLE   = 2'h1,
    SCR_ST_ANSWER = 2'h2
  } scr_state_t;

endpackage : scr_pkg

// >>> core/scr_write_fill.sv
// width shaping of control-register move data by operating mode
module scr_write_fill (
  input  wire logic [63:0] i_wdata,
  input  wire logic [63:0] i_rdata,
  input  wire logic        i_mode_64,
  output logic      [63:0] o_fill,
  output logic      [63:0] o_rdata,
  output logic             o_high_set
);

  always_comb begin
    if (i_mode_64) begin
      // operand-size prefix plays no part here
      o_fill  = i_wdata;
      o_rdata = i_rdata;
    end else begin
      o_fill  = i_wdata & scr_pkg::LOW_MASK;
      o_rdata = i_rdata & scr_pkg::LOW_MASK;
    end
    o_high_set = i_mode_64 & (|i_wdata[63:32]);
  end

endmodule : scr_write_fill

// >>> core/scr_coproc_check.sv
// coprocessor fault decision for one issuing instruction
module scr_coproc_check (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_valid,
  input  wire logic [2:0] i_kind,
  input  wire logic       i_monitor,
  input  wire logic       i_emulate,
  input  wire logic       i_switched,
  output logic            o_nm,
  output logic            o_ud
);

  logic is_wait;
  logic is_fp;
  logic is_media;

  always_comb begin
    is_wait  = i_valid & (i_kind == scr_pkg::KIND_WAIT);
    is_fp    = i_valid & (i_kind == scr_pkg::KIND_FP);
    is_media = i_valid & (i_kind == scr_pkg::KIND_MEDIA);
    // invalid opcode outranks the lazy-switch trap for media
    o_ud = is_media & i_emulate;
    o_nm = (is_wait & i_monitor & i_switched)
         | (is_fp & (i_emulate | i_switched))
         | (is_media & ~i_emulate & i_switched);
  end

  property p_wait_nm;
    @(posedge i_core_clk) disable iff (!i_nrst)
      is_wait |-> (o_nm == (i_monitor & i_switched));
  endproperty
  a_wait_nm: assert property (p_wait_nm)
    else $error("wait fault does not follow monitor and switched");

  property p_media_ud;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (is_media && i_emulate) |-> (o_ud && !o_nm);
  endproperty
  a_media_ud: assert property (p_media_ud)
    else $error("media with emulate did not raise invalid opcode");

  property p_fp_nm;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (is_fp && (i_emulate || i_switched)) |-> o_nm;
  endproperty
  a_fp_nm: assert property (p_fp_nm)
    else $error("fp instruction was not trapped");

endmodule : scr_coproc_check

// >>> core/scr_system_control_registers.sv
// system-control register bank with coprocessor fault gating
//
// Overview of operation
// - legacy: control and flags registers 32 bits; extended-feature 64
// - 64-bit mode moves access all 64 bits; size prefix ignored
// - other modes: writes zero the high half, reads give low half
// - 64-bit mode: high bits set in mode/feature write faults, code 0
// - fault-address fully writable, no virtual range check
// - table base writable except absent address bits; hardware zeroes
// - flags upper half reads zero, nonzero loads discarded
// - page fault loads fault-address with faulting virtual address
// - priority register only in 64-bit mode with extension prefix
// - bit 0 selects protected mode and enables segment checks
// - wait traps only when monitor and switched both set
// - emulate set traps every floating-point instruction as unavailable
// - emulate set makes media instructions invalid opcodes
// - emulate alone never traps the wait instruction
// - switched set traps floating-point and media instructions
// - hardware task switch sets the switched bit
// - switched cleared by clear instruction or mode-control write
// - extension-kind bit reads one, cannot be cleared
// - numeric-error zero: external ignore input governs fp exceptions
// - ignore high drops exceptions; low reports on error output
// - numeric-error one: internal reporting, external path off
// - priority register holds class in four low bits
module scr_system_control_registers #(
  parameter int unsigned PA_BITS = scr_pkg::PA_BITS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_mode_64,
  input  wire logic        i_mov_valid,
  input  wire logic        i_mov_write,
  input  wire logic [4:0]  i_mov_sel,
  input  wire logic [63:0] i_mov_wdata,
  input  wire logic        i_mov_rex,
  input  wire logic        i_mov_opsize,
  output logic             o_mov_ready,
  output logic             o_mov_done,
  output logic      [63:0] o_mov_rdata,
  output logic             o_protection_fault,
  output logic             o_mov_invalid,
  input  wire logic        i_page_fault,
  input  wire logic [63:0] i_fault_vaddr,
  input  wire logic        i_task_switch,
  input  wire logic        i_clear_switched_instr,
  input  wire logic        i_instr_valid,
  input  wire logic [2:0]  i_instr_kind,
  output logic             o_device_unavailable_fault,
  output logic             o_invalid_opcode_fault,
  output logic             o_instr_allow,
  input  wire logic        i_fp_exception,
  input  wire logic        i_fp_error_ignore_in,
  input  wire logic        i_fp_error_clear,
  output logic             o_fp_error_out,
  output logic             o_fp_internal_report,
  output logic             o_protection_on,
  output logic             o_segment_checks_on,
  output logic      [63:0] o_mode_control,
  output logic      [63:0] o_fault_address,
  output logic      [63:0] o_table_base,
  output logic      [63:0] o_feature_control,
  output logic      [3:0]  o_task_priority_threshold,
  output logic      [63:0] o_flags_register,
  output logic      [63:0] o_extended_feature
);

  localparam logic [63:0] PA_MASK =
    {{(64 - PA_BITS){1'b0}}, {PA_BITS{1'b1}}};

  scr_pkg::scr_state_t state_reg, state_next;
  logic [63:0] mode_control_reg,       mode_control_next;
  logic [63:0] fault_address_reg,      fault_address_next;
  logic [63:0] table_base_reg,         table_base_next;
  logic [63:0] feature_control_reg,    feature_control_next;
  logic [3:0]  priority_threshold_reg, priority_threshold_next;
  logic [63:0] flags_register_reg,     flags_register_next;
  logic [63:0] extended_feature_reg,   extended_feature_next;
  logic [63:0] rdata_reg,              rdata_next;
  logic        done_reg,               done_next;
  logic        gp_reg,                 gp_next;
  logic        inval_reg,              inval_next;
  logic        fp_err_reg,             fp_err_next;
  logic        fp_int_reg,             fp_int_next;

  logic        take, legal, wr_ok;
  logic [63:0] fill;
  logic [63:0] rd_raw;
  logic [63:0] rd_shaped;
  logic        high_set, nm, ud;

  scr_write_fill u_fill (
    .i_wdata    (i_mov_wdata),
    .i_rdata    (rd_raw),
    .i_mode_64  (i_mode_64),
    .o_fill     (fill),
    .o_rdata    (rd_shaped),
    .o_high_set (high_set)
  );

  scr_coproc_check u_coproc (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_valid    (i_instr_valid),
    .i_kind     (i_instr_kind),
    .i_monitor  (mode_control_reg[scr_pkg::BIT_MONITOR]),
    .i_emulate  (mode_control_reg[scr_pkg::BIT_EMULATE]),
    .i_switched (mode_control_reg[scr_pkg::BIT_SWITCHED]),
    .o_nm       (nm),
    .o_ud       (ud)
  );

  // faults are combinational so issue can be blocked in the same cycle
  assign o_device_unavailable_fault = nm;
  assign o_invalid_opcode_fault     = ud;
  assign o_instr_allow = i_instr_valid & ~nm & ~ud;
  assign o_mov_ready   = (state_reg == scr_pkg::SCR_ST_IDLE);

  always_comb begin
    take   = o_mov_ready & i_mov_valid;
    rd_raw = 64'h0000_0000_0000_0000;
    legal  = 1'b1;
    case (i_mov_sel)
      scr_pkg::SEL_MODE:     rd_raw = mode_control_reg;
      scr_pkg::SEL_FAULT:    rd_raw = fault_address_reg;
      scr_pkg::SEL_TABLE:    rd_raw = table_base_reg;
      scr_pkg::SEL_FEATURE:  rd_raw = feature_control_reg;
      scr_pkg::SEL_PRIORITY: begin
        rd_raw = {60'h0, priority_threshold_reg};
        legal  = i_mode_64 & i_mov_rex;
      end
      scr_pkg::SEL_FLAGS:    rd_raw = flags_register_reg;
      scr_pkg::SEL_EXTFEAT:  rd_raw = extended_feature_reg;
      default:               legal  = 1'b0;
    endcase
    // reserved high half of mode and feature control traps in 64-bit mode
    wr_ok = take & i_mov_write & legal
          & ~(high_set & ((i_mov_sel == scr_pkg::SEL_MODE)
          | (i_mov_sel == scr_pkg::SEL_FEATURE)));
  end

  always_comb begin
    state_next              = state_reg;
    mode_control_next       = mode_control_reg;
    fault_address_next      = fault_address_reg;
    table_base_next         = table_base_reg;
    feature_control_next    = feature_control_reg;
    priority_threshold_next = priority_threshold_reg;
    flags_register_next     = flags_register_reg;
    extended_feature_next   = extended_feature_reg;
    rdata_next              = rdata_reg;
    done_next               = take;
    gp_next                 = take & i_mov_write & legal & ~wr_ok;
    inval_next              = take & ~legal;
    case (state_reg)
      scr_pkg::SCR_ST_IDLE:   if (take) state_next = scr_pkg::SCR_ST_ANSWER;
      scr_pkg::SCR_ST_ANSWER: state_next = scr_pkg::SCR_ST_IDLE;
      default:                state_next = scr_pkg::SCR_ST_IDLE;
    endcase
    if (take & ~i_mov_write & legal) begin
      // the model-specific register never goes through the width shaper
      if (i_mov_sel == scr_pkg::SEL_EXTFEAT) begin
        rdata_next = extended_feature_reg;
      end else begin
        rdata_next = rd_shaped;
      end
    end
    if (i_clear_switched_instr) begin
      mode_control_next[scr_pkg::BIT_SWITCHED] = 1'b0;
    end
    if (wr_ok) begin
      case (i_mov_sel)
        scr_pkg::SEL_MODE:
          // a write also clears switched when data bit is zero
          mode_control_next = fill | scr_pkg::EXT_KIND_MASK;
        scr_pkg::SEL_FAULT:    fault_address_next = fill;
        scr_pkg::SEL_TABLE:    table_base_next = fill & PA_MASK;
        scr_pkg::SEL_FEATURE:  feature_control_next = fill;
        scr_pkg::SEL_PRIORITY:
          priority_threshold_next = i_mov_wdata[3:0];
        scr_pkg::SEL_FLAGS:
          flags_register_next = i_mov_wdata & scr_pkg::LOW_MASK;
        scr_pkg::SEL_EXTFEAT:  extended_feature_next = i_mov_wdata;
        default:               mode_control_next = mode_control_next;
      endcase
    end
    // hardware events outrank software in the same cycle
    if (i_page_fault) begin
      fault_address_next = i_fault_vaddr;
    end
    if (i_task_switch) begin
      mode_control_next[scr_pkg::BIT_SWITCHED] = 1'b1;
    end
  end

  always_comb begin
    fp_int_next = i_fp_exception & mode_control_reg[scr_pkg::BIT_NUMERIC];
    if (mode_control_reg[scr_pkg::BIT_NUMERIC]) begin
      fp_err_next = 1'b0;
    end else begin
      // set wins over an external clear in the same cycle
      fp_err_next = (fp_err_reg & ~i_fp_error_clear)
                  | (i_fp_exception & ~i_fp_error_ignore_in);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_reg              <= scr_pkg::SCR_ST_IDLE;
      mode_control_reg       <= scr_pkg::MODE_RESET;
      fault_address_reg      <= scr_pkg::ZERO_RESET;
      table_base_reg         <= scr_pkg::ZERO_RESET;
      feature_control_reg    <= scr_pkg::ZERO_RESET;
      priority_threshold_reg <= 4'h0;
      flags_register_reg     <= scr_pkg::ZERO_RESET;
      extended_feature_reg   <= scr_pkg::ZERO_RESET;
      rdata_reg              <= scr_pkg::ZERO_RESET;
      done_reg               <= 1'b0;
      gp_reg                 <= 1'b0;
      inval_reg              <= 1'b0;
      fp_err_reg             <= 1'b0;
      fp_int_reg             <= 1'b0;
    end else begin
      state_reg              <= state_next;
      mode_control_reg       <= mode_control_next;
      fault_address_reg      <= fault_address_next;
      table_base_reg         <= table_base_next;
      feature_control_reg    <= feature_control_next;
      priority_threshold_reg <= priority_threshold_next;
      flags_register_reg     <= flags_register_next;
      extended_feature_reg   <= extended_feature_next;
      rdata_reg              <= rdata_next;
      done_reg               <= done_next;
      gp_reg                 <= gp_next;
      inval_reg              <= inval_next;
      fp_err_reg             <= fp_err_next;
      fp_int_reg             <= fp_int_next;
    end
  end

  assign o_mov_done                = done_reg;
  assign o_mov_rdata               = rdata_reg;
  assign o_protection_fault        = gp_reg;
  assign o_mov_invalid             = inval_reg;
  assign o_fp_error_out            = fp_err_reg;
  assign o_fp_internal_report      = fp_int_reg;
  assign o_protection_on = mode_control_reg[scr_pkg::BIT_PROTECTION];
  assign o_segment_checks_on =
    mode_control_reg[scr_pkg::BIT_PROTECTION];
  assign o_mode_control            = mode_control_reg;
  assign o_fault_address           = fault_address_reg;
  assign o_table_base              = table_base_reg;
  assign o_feature_control         = feature_control_reg;
  assign o_task_priority_threshold = priority_threshold_reg;
  assign o_flags_register          = flags_register_reg;
  assign o_extended_feature        = extended_feature_reg;

  property p_ext_kind_one;
    @(posedge i_core_clk) disable iff (!i_nrst)
      mode_control_reg[scr_pkg::BIT_EXT_KIND];
  endproperty
  a_ext_kind_one: assert property (p_ext_kind_one)
    else $error("extension-kind bit read as zero");

  property p_flags_upper;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (take && i_mov_write && i_mov_sel == scr_pkg::SEL_FLAGS)
        |=> (flags_register_reg[63:32] == 32'h0000_0000);
  endproperty
  a_flags_upper: assert property (p_flags_upper)
    else $error("flags upper half not zero after write");

  property p_high_gp;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (take && i_mov_write && i_mode_64 && (|i_mov_wdata[63:32])
        && i_mov_sel == scr_pkg::SEL_FEATURE)
        |=> (o_protection_fault && $stable(feature_control_reg));
  endproperty
  a_high_gp: assert property (p_high_gp)
    else $error("reserved high write did not fault");

  property p_legacy_fill;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (take && i_mov_write && !i_mode_64 && !i_page_fault
        && i_mov_sel == scr_pkg::SEL_FAULT)
        |=> (fault_address_reg == ($past(i_mov_wdata) & scr_pkg::LOW_MASK));
  endproperty
  a_legacy_fill: assert property (p_legacy_fill)
    else $error("legacy write did not zero the high half");

  property p_full_write;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (take && i_mov_write && i_mode_64 && !i_page_fault
        && i_mov_sel == scr_pkg::SEL_FAULT)
        |=> (fault_address_reg == $past(i_mov_wdata));
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("fault address not written with all 64 bits");

  property p_page_fault;
    @(posedge i_core_clk) disable iff (!i_nrst)
      i_page_fault |=> (fault_address_reg == $past(i_fault_vaddr));
  endproperty
  a_page_fault: assert property (p_page_fault)
    else $error("page fault address not captured");

  property p_task_switch;
    @(posedge i_core_clk) disable iff (!i_nrst)
      i_task_switch |=> mode_control_reg[scr_pkg::BIT_SWITCHED] [*1];
  endproperty
  a_task_switch: assert property (p_task_switch)
    else $error("task switch did not set switched bit");

  property p_clear_switched;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (i_clear_switched_instr && !i_task_switch && !wr_ok)
        |=> !mode_control_reg[scr_pkg::BIT_SWITCHED];
  endproperty
  a_clear_switched: assert property (p_clear_switched)
    else $error("clear instruction left switched bit set");

  property p_priority_gate;
    @(posedge i_core_clk) disable iff (!i_nrst)
      (take && i_mov_sel == scr_pkg::SEL_PRIORITY && !(i_mode_64 && i_mov_rex))
        |=> (o_mov_invalid && $stable(priority_threshold_reg));
  endproperty
  a_priority_gate: assert property (p_priority_gate)
    else $error("priority register reached without 64-bit prefix");

  property p_numeric_internal;
    @(posedge i_core_clk) disable iff (!i_nrst)
      mode_control_reg[scr_pkg::BIT_NUMERIC] |=> !o_fp_error_out;
  endproperty
  a_numeric_internal: assert property (p_numeric_internal)
    else $error("external error path active with numeric-error set");

endmodule : scr_system_control_registers

// >>> verification/tb.sv
// self-checking testbench for the system-control register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned PA = 40;

  logic        clk, nrst, m64, mv, mw, register_extension_prefix, ops;
  logic        pgf, tsw, clr, iv, fpx, ign, fclr;
  logic [4:0]  sel;
  logic [2:0]  kind;
  logic [63:0] wdata, vaddr;
  logic        rdy, done, gp, inv, nm, ud, allow, fperr, fprep, pon, segon;
  logic [63:0] rdata, mode, fa, tbase, feat, flg, ext;
  logic [3:0]  prio;
  logic [63:0] r_data;
  logic        r_gp, r_inv;
  int          num_errors, cmp_count;

  scr_system_control_registers #(.PA_BITS(PA)) u_scr_system_control_registers (
    .i_core_clk(clk), .i_nrst(nrst), .i_mode_64(m64),
    .i_mov_valid(mv), .i_mov_write(mw), .i_mov_sel(sel),
    .i_mov_wdata(wdata), .i_mov_rex(register_extension_prefix), .i_mov_opsize(ops),
    .o_mov_ready(rdy), .o_mov_done(done), .o_mov_rdata(rdata),
    .o_protection_fault(gp), .o_mov_invalid(inv),
    .i_page_fault(pgf), .i_fault_vaddr(vaddr), .i_task_switch(tsw),
    .i_clear_switched_instr(clr), .i_instr_valid(iv),
    .i_instr_kind(kind), .o_device_unavailable_fault(nm),
    .o_invalid_opcode_fault(ud), .o_instr_allow(allow),
    .i_fp_exception(fpx), .i_fp_error_ignore_in(ign),
    .i_fp_error_clear(fclr), .o_fp_error_out(fperr),
    .o_fp_internal_report(fprep), .o_protection_on(pon),
    .o_segment_checks_on(segon), .o_mode_control(mode),
    .o_fault_address(fa), .o_table_base(tbase),
    .o_feature_control(feat), .o_task_priority_threshold(prio),
    .o_flags_register(flg), .o_extended_feature(ext)
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nme, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nme, e, g);
    end
  endtask : chk

  task close_out;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // request is held up to the taking edge, answer sampled mid-cycle
  task automatic mov(input logic w, input logic [4:0] s,
                     input logic [63:0] d, input logic x);
    int  n;
    bit  got;
    n = 0;
    got = 0;
    @(posedge clk);
    mv <= 1'h1;
    mw <= w;
    sel <= s;
    wdata <= d;
    register_extension_prefix <= x;
    @(posedge clk);
    mv <= 1'h0;
    while (!got && n < 4) begin
      @(negedge clk);
      if (done === 1'h1) begin
        got = 1;
        r_data = rdata;
        r_gp = gp;
        r_inv = inv;
      end
      n++;
    end
    if (!got) begin
      num_errors++;
      $display("wrong value done expected 1 seen 0");
      close_out();
    end
    @(posedge clk);
  endtask : mov

  // one-cycle strobe: 0 page fault, 1 task switch, 2 clear, 3 fp, 4 fp clear
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: pgf <= 1'h1;
      1: tsw <= 1'h1;
      2: clr <= 1'h1;
      3: fpx <= 1'h1;
      default: fclr <= 1'h1;
    endcase
    @(posedge clk);
    {pgf, tsw, clr, fpx, fclr} <= '0;
    @(negedge clk);
  endtask : pulse

  task automatic ins(input logic [2:0] k, input logic enm, input logic eud);
    @(posedge clk);
    iv <= 1'h1;
    kind <= k;
    @(negedge clk);
    chk("nm", {63'h0, enm}, {63'h0, nm});
    chk("ud", {63'h0, eud}, {63'h0, ud});
    chk("allow", {63'h0, !(enm | eud)}, {63'h0, allow});
    @(posedge clk);
    iv <= 1'h0;
  endtask : ins

  task automatic t_width;
    @(posedge clk);
    m64 <= 1'h1;
    ops <= 1'h1;
    mov(1'h1, scr_pkg::SEL_FAULT, 64'hFEDC_BA98_7654_3210, 1'h0);
    chk("fa64", 64'hFEDC_BA98_7654_3210, fa);
    mov(1'h0, scr_pkg::SEL_FAULT, 64'h0, 1'h0);
    chk("rd64", 64'hFEDC_BA98_7654_3210, r_data);
    m64 <= 1'h0;
    mov(1'h0, scr_pkg::SEL_FAULT, 64'h0, 1'h0);
    chk("rd32", 64'h0000_0000_7654_3210, r_data);
    mov(1'h1, scr_pkg::SEL_FAULT, 64'h1234_5678_9ABC_DEF0, 1'h0);
    chk("fa32", 64'h0000_0000_9ABC_DEF0, fa);
    mov(1'h1, scr_pkg::SEL_EXTFEAT, 64'hA5A5_0000_0000_0101, 1'h0);
    chk("ext", 64'hA5A5_0000_0000_0101, ext);
    mov(1'h0, scr_pkg::SEL_EXTFEAT, 64'h0, 1'h0);
    chk("rdext", 64'hA5A5_0000_0000_0101, r_data);
    mov(1'h1, scr_pkg::SEL_MODE, 64'h0000_0001_0000_0000, 1'h0);
    chk("gp32", 64'h0, {63'h0, r_gp});
    chk("mode32", 64'h10, mode);
  endtask : t_width

  task automatic t_guard;
    m64 <= 1'h1;
    mov(1'h1, scr_pkg::SEL_MODE, 64'h0000_0001_0000_0031, 1'h0);
    chk("gpmode", 64'h1, {63'h0, r_gp});
    chk("mode", 64'h10, mode);
    mov(1'h1, scr_pkg::SEL_FEATURE, 64'h8000_0000_0000_0000, 1'h0);
    chk("gpfeat", 64'h1, {63'h0, r_gp});
    chk("feat", 64'h0, feat);
    mov(1'h1, scr_pkg::SEL_FEATURE, 64'h0000_0000_0000_00A0, 1'h0);
    chk("gpfok", 64'h0, {63'h0, r_gp});
    chk("featok", 64'h0000_0000_0000_00A0, feat);
    mov(1'h1, scr_pkg::SEL_TABLE, 64'hFFFF_FFFF_FFFF_FFFF, 1'h0);
    chk("table", (64'h1 << PA) - 64'h1, tbase);
    mov(1'h1, scr_pkg::SEL_FLAGS, 64'hFFFF_FFFF_0000_0A5A, 1'h0);
    chk("flags", 64'h0A5A, flg);
    mov(1'h1, scr_pkg::SEL_PRIORITY, 64'hF, 1'h0);
    chk("noprefix", 64'h1, {63'h0, r_inv});
    mov(1'h1, scr_pkg::SEL_PRIORITY, 64'h3A, 1'h1);
    chk("prio", 64'hA, {60'h0, prio});
    mov(1'h1, 5'h01, 64'h0, 1'h0);
    chk("badsel", 64'h1, {63'h0, r_inv});
    m64 <= 1'h0;
    mov(1'h1, scr_pkg::SEL_PRIORITY, 64'h5, 1'h1);
    chk("prio32", 64'h1, {63'h0, r_inv});
    vaddr <= 64'hFFFF_8000_0000_1234;
    pulse(0);
    chk("pagefa", 64'hFFFF_8000_0000_1234, fa);
  endtask : t_guard

  task automatic t_coproc;
    mov(1'h1, scr_pkg::SEL_MODE, 64'h03, 1'h0);
    chk("pe", 64'h3, {62'h0, segon, pon});
    chk("et", 64'h13, mode);
    ins(scr_pkg::KIND_WAIT, 1'h0, 1'h0);
    pulse(1);
    chk("tsset", 64'h1B, mode);
    ins(scr_pkg::KIND_WAIT, 1'h1, 1'h0);
    ins(scr_pkg::KIND_FP, 1'h1, 1'h0);
    ins(scr_pkg::KIND_MEDIA, 1'h1, 1'h0);
    pulse(2);
    chk("tsclr", 64'h13, mode);
    ins(scr_pkg::KIND_FP, 1'h0, 1'h0);
    mov(1'h1, scr_pkg::SEL_MODE, 64'h04, 1'h0);
    chk("peoff", 64'h0, {62'h0, segon, pon});
    ins(scr_pkg::KIND_WAIT, 1'h0, 1'h0);
    ins(scr_pkg::KIND_FP, 1'h1, 1'h0);
    ins(scr_pkg::KIND_MEDIA, 1'h0, 1'h1);
    pulse(1);
    mov(1'h1, scr_pkg::SEL_MODE, 64'h00, 1'h0);
    chk("tswrite", 64'h10, mode);
  endtask : t_coproc

  task automatic t_fp;
    pulse(3);
    chk("fp_error_out", 64'h1, {63'h0, fperr});
    pulse(4);
    chk("fclr", 64'h0, {63'h0, fperr});
    @(posedge clk);
    ign <= 1'h1;
    pulse(3);
    chk("fign", 64'h0, {63'h0, fperr});
    mov(1'h1, scr_pkg::SEL_MODE, 64'h30, 1'h0);
    @(posedge clk);
    ign <= 1'h0;
    pulse(3);
    chk("frep", 64'h1, {63'h0, fprep});
    chk("fint", 64'h0, {63'h0, fperr});
  endtask : t_fp

  initial begin
    num_errors = 0;
    cmp_count = 0;
    {nrst, m64, mv, mw, register_extension_prefix, ops, pgf, tsw, clr, iv, fpx, ign, fclr} = '0;
    sel = 5'h00;
    kind = 3'h0;
    wdata = 64'h0;
    vaddr = 64'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    chk("rstmode", scr_pkg::MODE_RESET, mode);
    chk("rstready", 64'h1, {63'h0, rdy});
    t_width();
    t_guard();
    t_coproc();
    t_fp();
    close_out();
  end

endmodule : tb
